// >>> src/sbrb_cfg.svh
`ifndef SBRB_CFG_SVH
`define SBRB_CFG_SVH

// ----------------------------------------------------------------------
// widths and defaults
// ----------------------------------------------------------------------
`define SBRB_DATA_W 16
`define SBRB_CHAN_W 8
`define SBRB_LEN_W 5
`define SBRB_MAX_LOG 10
`define SBRB_FIFO_DEPTH 16

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SBRB_MODE_RST 1'b0
`define SBRB_IDX_RST '0

`endif

// >>> src/sbrb_fifo.sv
`include "sbrb_cfg.svh"

// ----------------------------------------------------------------------
// output fifo, depth must be a power of two
// ----------------------------------------------------------------------
module sbrb_fifo #(
    parameter int WIDTH = 45,
    parameter int DEPTH = `SBRB_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // fill side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // drain side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [LW-1:0] count;
    } sbrb_fifo_state_t;

    sbrb_fifo_state_t st_ff;
    sbrb_fifo_state_t nxt_st;
    logic push;
    logic pop;

    // honest flags straight from the count
    assign s_ready = st_ff.count != LW'(DEPTH);
    assign m_valid = st_ff.count != '0;
    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;

    // pointer and count update
    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.mem[st_ff.wp] = s_data;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (pop)
        begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_st.count = st_ff.count + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_st.count = st_ff.count - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign m_data = st_ff.mem[st_ff.rp];
    assign level = st_ff.count;
endmodule

// >>> src/sbrb_frame_mem.sv
// ----------------------------------------------------------------------
// frame store: one write and one registered read per cycle
// ----------------------------------------------------------------------
module sbrb_frame_mem #(
    parameter int WIDTH = 40,
    parameter int AW = 10
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    localparam int DEPTH = 2 ** AW;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] store;
        logic [WIDTH-1:0] rdata;
    } sbrb_mem_state_t;

    sbrb_mem_state_t st_ff;
    sbrb_mem_state_t nxt_st;

    // read sees the old word when both ports hit one slot, which is
    // exactly what back-to-back frames rely on
    always_comb
    begin
        nxt_st = st_ff;
        if (rd_en)
        begin
            nxt_st.rdata = st_ff.store[rd_addr];
        end
        if (wr_en)
        begin
            nxt_st.store[wr_addr] = wr_data;
        end
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rdata;
endmodule

// >>> src/sbrb_pkg.sv
`include "sbrb_cfg.svh"

package sbrb_pkg;

    // ------------------------------------------------------------------
    // sample carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`SBRB_DATA_W-1:0] re;
        logic [`SBRB_DATA_W-1:0] im;
    } sbrb_cplx_t;

    // one stored slot: channel travels with its sample
    typedef struct packed {
        logic [`SBRB_CHAN_W-1:0] chan;
        sbrb_cplx_t cplx;
    } sbrb_entry_t;

    // one output word, frame length carried alongside
    typedef struct packed {
        logic [`SBRB_LEN_W-1:0] log_len;
        sbrb_entry_t entry;
    } sbrb_word_t;

    // ------------------------------------------------------------------
    // reader states
    // ------------------------------------------------------------------
    typedef enum logic {
        RD_IDLE,
        RD_DRAIN
    } sbrb_rd_state_t;

endpackage

// >>> src/sbrb_top.sv
`include "sbrb_cfg.svh"

module sbrb_top #(
    parameter int LOG_MAX = `SBRB_MAX_LOG,
    parameter bit VARIABLE = 1'b1,
    parameter int FIFO_DEPTH = `SBRB_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // sample input
    input wire logic input_valid,
    output logic input_ready,
    input wire logic [`SBRB_CHAN_W-1:0] input_channel,
    input wire sbrb_pkg::sbrb_cplx_t input_data,
    input wire logic [`SBRB_LEN_W-1:0] input_log_length,
    // reordered output
    output logic output_valid_flag,
    input wire logic output_ready,
    output logic [`SBRB_CHAN_W-1:0] output_channel_tag,
    output sbrb_pkg::sbrb_cplx_t output_data,
    output logic [`SBRB_LEN_W-1:0] output_frame_log_length
);
    localparam int LEN_W = `SBRB_LEN_W;
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int EW = $bits(sbrb_pkg::sbrb_entry_t);
    localparam int WW = $bits(sbrb_pkg::sbrb_word_t);

    // ------------------------------------------------------------------
    // address helpers
    // ------------------------------------------------------------------

    // reverse the low len bits of idx, or pass it through
    function automatic logic [LOG_MAX-1:0] slot_of(
        input logic [LOG_MAX-1:0] idx,
        input logic [LEN_W-1:0] len,
        input logic rev
    );
        logic [LOG_MAX-1:0] r;
        r = '0;
        for (int k = 0; k < LOG_MAX; k++)
        begin
            if (k < int'(len))
            begin
                r[k] = idx[int'(len) - 1 - k];
            end
        end
        return rev ? r : idx;
    endfunction

    // last index of a frame of 2**len samples
    function automatic logic [LOG_MAX-1:0] last_of(
        input logic [LEN_W-1:0] len
    );
        logic [LOG_MAX-1:0] m;
        m = '1;
        return ~(m << len);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr_busy;
        logic [LOG_MAX-1:0] wr_idx;
        logic [LEN_W-1:0] wr_len;
        logic wr_mode;
        sbrb_pkg::sbrb_rd_state_t rd_state;
        logic [LOG_MAX-1:0] rd_idx;
        logic [LEN_W-1:0] rd_len;
        logic rd_mode;
        logic pend;
        logic [LEN_W-1:0] pend_len;
    } sbrb_state_t;

    sbrb_state_t st_ff;
    sbrb_state_t nxt_st;

    logic [LEN_W-1:0] eff_len;
    logic [LEN_W-1:0] cur_len;
    logic [LW-1:0] fifo_level;
    logic room;
    logic rd_issue;
    logic wr_fire;
    logic wr_last;
    logic push_ready;
    logic [LOG_MAX-1:0] wr_addr;
    logic [LOG_MAX-1:0] rd_addr;
    logic [EW-1:0] rd_entry;
    sbrb_pkg::sbrb_word_t push_word;
    sbrb_pkg::sbrb_word_t pop_word;
    logic [LOG_MAX-1:0] full_rev;

    // ------------------------------------------------------------------
    // handshake terms
    // ------------------------------------------------------------------

    // fixed variant ignores the size input; out-of-range sizes clamp
    assign eff_len = !VARIABLE ? LEN_W'(LOG_MAX) :
        (input_log_length > LEN_W'(LOG_MAX)) ? LEN_W'(LOG_MAX) :
        input_log_length;
    // length is frozen once a frame has started
    assign cur_len = st_ff.wr_busy ? st_ff.wr_len : eff_len;

    // count the read in flight so the fifo can never overflow
    assign room = ({1'b0, fifo_level} + (LW + 1)'(st_ff.pend))
        < (LW + 1)'(FIFO_DEPTH);
    assign rd_issue = (st_ff.rd_state == sbrb_pkg::RD_DRAIN) && room;

    // a write may only land on a slot already read; a new length must
    // wait for an empty buffer since slot mappings would disagree
    always_comb
    begin
        input_ready = 1'b1;
        if (st_ff.rd_state == sbrb_pkg::RD_DRAIN)
        begin
            if (!st_ff.wr_busy && (cur_len != st_ff.rd_len))
            begin
                input_ready = 1'b0;
            end
            else
            begin
                input_ready = (st_ff.wr_idx < st_ff.rd_idx) ||
                    ((st_ff.wr_idx == st_ff.rd_idx) && rd_issue);
            end
        end
    end

    assign wr_fire = input_valid && input_ready;
    assign wr_last = wr_fire && (st_ff.wr_idx == last_of(cur_len));

    // new frame takes the slots in the order the old one is read out
    assign wr_addr = slot_of(st_ff.wr_idx, cur_len, st_ff.wr_mode);
    assign rd_addr = slot_of(st_ff.rd_idx, st_ff.rd_len, st_ff.rd_mode);

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------

    // read side first, so a frame end overrides the reader fields
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pend = rd_issue;
        nxt_st.pend_len = st_ff.rd_len;
        if (rd_issue)
        begin
            if (st_ff.rd_idx == last_of(st_ff.rd_len))
            begin
                nxt_st.rd_state = sbrb_pkg::RD_IDLE;
                nxt_st.rd_idx = `SBRB_IDX_RST;
            end
            else
            begin
                nxt_st.rd_idx = st_ff.rd_idx + 1'b1;
            end
        end
        if (wr_fire)
        begin
            if (wr_last)
            begin
                // full frame stored: start its readout next cycle
                nxt_st.wr_busy = 1'b0;
                nxt_st.wr_idx = `SBRB_IDX_RST;
                nxt_st.wr_mode = !st_ff.wr_mode;
                nxt_st.rd_state = sbrb_pkg::RD_DRAIN;
                nxt_st.rd_idx = `SBRB_IDX_RST;
                nxt_st.rd_len = cur_len;
                nxt_st.rd_mode = !st_ff.wr_mode;
            end
            else
            begin
                nxt_st.wr_busy = 1'b1;
                nxt_st.wr_idx = st_ff.wr_idx + 1'b1;
                nxt_st.wr_len = cur_len;
            end
        end
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.wr_mode <= `SBRB_MODE_RST;
            st_ff.rd_state <= sbrb_pkg::RD_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // storage and output path
    // ------------------------------------------------------------------

    // single frame buffer of 2**LOG_MAX slots
    sbrb_frame_mem #(
        .WIDTH(EW),
        .AW(LOG_MAX)
    ) u_mem (
        .clock(clock),
        .reset_n(reset_n),
        .wr_en(wr_fire),
        .wr_addr(wr_addr),
        .wr_data({input_channel, input_data}),
        .rd_en(rd_issue),
        .rd_addr(rd_addr),
        .rd_data(rd_entry)
    );

    // channel stays glued to its sample through the fifo
    assign push_word = {st_ff.pend_len, rd_entry};

    sbrb_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .s_valid(st_ff.pend),
        .s_ready(push_ready),
        .s_data(push_word),
        .m_valid(output_valid_flag),
        .m_ready(output_ready),
        .m_data(pop_word),
        .level(fifo_level)
    );

    // output fields
    assign output_channel_tag = pop_word.entry.chan;
    assign output_data = pop_word.entry.cplx;
    assign output_frame_log_length = pop_word.log_len;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    assign full_rev = {<<{st_ff.rd_idx}};

    a_drain_after_frame:
    assert property (@(posedge clock) disable iff (!reset_n)
        wr_last |=> (st_ff.rd_state == sbrb_pkg::RD_DRAIN) &&
        (st_ff.rd_idx == '0) && (st_ff.rd_len == $past(cur_len)))
    else $error("readout did not start after a full frame");

    a_read_latency_len:
    assert property (@(posedge clock) disable iff (!reset_n)
        rd_issue |=> st_ff.pend && (st_ff.pend_len == $past(st_ff.rd_len)))
    else $error("read result or its length went astray");

    a_full_rev_map:
    assert property (@(posedge clock) disable iff (!reset_n)
        rd_issue && st_ff.rd_mode && (st_ff.rd_len == LEN_W'(LOG_MAX))
        |-> rd_addr == full_rev)
    else $error("read slot is not the bit reversed index");

    a_natural_write:
    assert property (@(posedge clock) disable iff (!reset_n)
        wr_fire && !st_ff.wr_mode |-> wr_addr == st_ff.wr_idx)
    else $error("natural write slot wrong");

    a_mode_flip:
    assert property (@(posedge clock) disable iff (!reset_n)
        wr_last |=> (st_ff.wr_mode != $past(st_ff.wr_mode)) &&
        (st_ff.rd_mode == st_ff.wr_mode))
    else $error("slot mapping did not alternate");

    a_no_overrun:
    assert property (@(posedge clock) disable iff (!reset_n)
        wr_fire && (st_ff.rd_state == sbrb_pkg::RD_DRAIN) |->
        (st_ff.wr_idx < st_ff.rd_idx) ||
        ((st_ff.wr_idx == st_ff.rd_idx) && rd_issue))
    else $error("write overtook unread sample");

    a_size_block:
    assert property (@(posedge clock) disable iff (!reset_n)
        input_valid && !st_ff.wr_busy && (eff_len != st_ff.rd_len) &&
        (st_ff.rd_state == sbrb_pkg::RD_DRAIN) |-> !input_ready)
    else $error("new length accepted before buffer drained");

    a_len_capture:
    assert property (@(posedge clock) disable iff (!reset_n)
        wr_fire && !st_ff.wr_busy && !wr_last |=>
        st_ff.wr_busy && (st_ff.wr_len == $past(eff_len)))
    else $error("frame length not captured at first sample");

    a_fifo_room:
    assert property (@(posedge clock) disable iff (!reset_n)
        st_ff.pend |-> push_ready)
    else $error("reordered sample dropped at full fifo");

    a_drain_ends:
    assert property (@(posedge clock) disable iff (!reset_n)
        rd_issue && (st_ff.rd_idx == last_of(st_ff.rd_len)) && !wr_last
        |=> st_ff.rd_state == sbrb_pkg::RD_IDLE)
    else $error("readout ran past the frame end");
endmodule

// >>> verif/sbrb_fft_sink.sv
// ----------------------------------------------------------------------
// downstream stage model: takes reordered words at a chosen pace
// ----------------------------------------------------------------------
module sbrb_fft_sink (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // pace: 0 prompt, 1 one word in three, 2 stopped
    input wire logic [1:0] pace,
    // downstream handshake
    input wire logic output_valid_flag,
    output logic output_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] tick_ff;

    // slow pace lets the output fifo back up and stall the input side
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            tick_ff <= 2'h0;
            output_ready <= 1'b0;
        end
        else
        begin
            // pace counts offered cycles only, so idle gaps do not
            // shift the one-in-three pattern
            if (output_valid_flag)
            begin
                tick_ff <= (tick_ff == 2'h2) ? 2'h0 : tick_ff + 2'h1;
            end
            output_ready <= (pace == 2'h0) ||
                (pace == 2'h1 && tick_ff == 2'h0);
        end
    end
endmodule

// >>> verif/tb_streaming_bit_reverse_buffer.sv
`include "sbrb_cfg.svh"

module tb_streaming_bit_reverse_buffer;
    timeunit 1ns;
    timeprecision 100ps;

    // small maximum keeps every frame length reachable in a short run
    localparam int LMAX = 5;

    logic clock, reset_n, input_valid, input_ready;
    logic output_valid_flag, output_ready;
    logic [`SBRB_CHAN_W-1:0] input_channel, output_channel_tag;
    sbrb_pkg::sbrb_cplx_t input_data, output_data;
    logic [`SBRB_LEN_W-1:0] input_log_length, output_frame_log_length;
    logic [1:0] pace;
    int err_count, tests_run, seed, cyc, start;
    logic [31:0] exp_d[$];
    logic [7:0] exp_c[$];
    logic [4:0] exp_l[$];

    // ------------------------------------------------------------------
    // design, downstream model, clock
    // ------------------------------------------------------------------
    sbrb_top #(.LOG_MAX(LMAX), .VARIABLE(1'b1), .FIFO_DEPTH(16)) DUT (
        .clock(clock), .reset_n(reset_n),
        .input_valid(input_valid), .input_ready(input_ready),
        .input_channel(input_channel), .input_data(input_data),
        .input_log_length(input_log_length),
        .output_valid_flag(output_valid_flag), .output_ready(output_ready),
        .output_channel_tag(output_channel_tag), .output_data(output_data),
        .output_frame_log_length(output_frame_log_length)
    );

    sbrb_fft_sink u_sink (
        .clock(clock), .reset_n(reset_n), .pace(pace),
        .output_valid_flag(output_valid_flag), .output_ready(output_ready)
    );

    // free-running clock and edge counter
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock)
        cyc <= cyc + 1;

    // ------------------------------------------------------------------
    // comparisons and reference model
    // ------------------------------------------------------------------
    task automatic cmp_data(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_meta(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bit-reversed index over lg bits; an involution, so usable both ways
    function automatic int rev_idx(input int k, input int lg);
        int r;
        r = 0;
        for (int b = 0; b < lg; b++)
            r = (r << 1) | ((k >> b) & 1);
        return r;
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one whole frame on consecutive accepted cycles, valid left high
    task automatic send_frame(input int lg, input int ch0);
        int n;
        int tries;
        logic [31:0] smp[];
        logic [7:0] tag[];
        n = 1 << lg;
        smp = new[n];
        tag = new[n];
        for (int k = 0; k < n; k++)
        begin
            smp[k] = $random(seed);
            tag[k] = 8'(ch0 + k);
            input_valid <= 1'b1;
            input_data <= smp[k];
            input_channel <= tag[k];
            input_log_length <= 5'(lg);
            tries = 0;
            @(negedge clock);
            while (input_ready !== 1'b1 && tries < 500)
            begin
                @(negedge clock);
                tries++;
            end
            cmp_meta("input_ready", 8'h01, {7'h0, input_ready});
            @(posedge clock);
        end
        for (int p = 0; p < n; p++)
        begin
            exp_d.push_back(smp[rev_idx(p, lg)]);
            exp_c.push_back(tag[rev_idx(p, lg)]);
            exp_l.push_back(5'(lg));
        end
    endtask

    task automatic idle(input int n);
        input_valid <= 1'b0;
        input_data <= $random(seed);
        repeat (n) @(posedge clock);
    endtask

    // bounded wait until every expected word has come out
    task automatic drain();
        int t;
        t = 0;
        idle(1);
        while (exp_d.size() != 0 && t < 5000)
        begin
            @(posedge clock);
            t++;
        end
        cmp_meta("words left", 8'h00, 8'(exp_d.size()));
    endtask

    // taken words checked where settled, half a cycle before the edge
    always @(negedge clock)
    begin
        if (reset_n === 1'b1 && output_valid_flag === 1'b1 &&
            output_ready === 1'b1)
        begin
            if (exp_d.size() == 0)
                cmp_meta("early output", 8'h00, 8'h01);
            else
            begin
                cmp_data("output_data", exp_d.pop_front(), output_data);
                cmp_meta("tag", exp_c.pop_front(), output_channel_tag);
                cmp_meta("log length", {3'h0, exp_l.pop_front()},
                    {3'h0, output_frame_log_length});
            end
        end
    end

    // hang guard, well above the thousand or so cycles needed
    initial
    begin
        #(50 * 30000);
        err_count++;
        test_done();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        seed = 65;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        pace = 2'h0;
        reset_n = 1'b0;
        input_valid = 1'b0;
        input_channel = 8'h00;
        input_data = 32'h0;
        input_log_length = 5'h0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        cmp_meta("valid after reset", 8'h00, {7'h0, output_valid_flag});
        @(posedge clock);
        // same size back to back: one buffer still takes every cycle
        start = cyc;
        repeat (3) send_frame(3, 8'h10);
        cmp_meta("stream cycles", 8'h18, 8'(cyc - start));
        drain();
        idle(8);
        // every length up to the maximum, size changes after a flush
        for (int lg = 0; lg <= LMAX; lg++)
        begin
            send_frame(lg, lg * 16);
            send_frame(lg, lg * 16 + 8);
            drain();
            idle(1 << lg);
        end
        // random gaps between frames of one size
        repeat (4)
        begin
            send_frame(2, $random(seed));
            idle(1 + ($random(seed) & 7));
        end
        // slow sink: fifo backs up, input side throttled
        pace <= 2'h1;
        repeat (3) send_frame(LMAX, 8'h40);
        drain();
        // stopped sink: buffer fills until refused, then drains
        pace <= 2'h2;
        fork
            begin
                send_frame(LMAX, 8'h80);
                send_frame(LMAX, 8'hA0);
            end
            begin
                repeat (90) @(negedge clock);
                cmp_meta("ready when full", 8'h00, {7'h0, input_ready});
                cmp_meta("valid when full", 8'h01,
                    {7'h0, output_valid_flag});
                @(posedge clock);
                pace <= 2'h0;
            end
        join
        drain();
        test_done();
    end
endmodule
